/* src/pbd_pkg.sv */
package pbd_pkg;
  // shared timebase tick of 0.5 ms
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 500000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SWCMD = 8'h04;
  localparam logic [7:0] A_CYC = 8'h08;
  localparam logic [7:0] A_DIM = 8'h0c;
  localparam logic [7:0] A_START = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam int NREG = 5;
  localparam logic [2:0] STAT_IDX = 3'h5;
  // ctrl fields
  localparam int C_MODE = 0;
  localparam int C_OP = 1;
  localparam int C_STOP = 4;
  localparam int C_REP = 5;
  localparam int C_BRR = 6;
  localparam int C_CYC = 8;
  // switch command fields: rise/fall for object 1 and 2
  localparam int S_R1 = 0;
  localparam int S_F1 = 2;
  localparam int S_R2 = 4;
  localparam int S_F2 = 6;
  // cyclic fields
  localparam int Y_B1 = 0;
  localparam int Y_B2 = 4;
  localparam int Y_FAC = 8;
  // dimming fields
  localparam int D_UP = 0;
  localparam int D_DN = 3;
  localparam int D_LB = 6;
  localparam int D_LF = 8;
  localparam int D_RB = 16;
  localparam int D_RF = 18;
  // startup and debounce fields
  localparam int P_SB = 0;
  localparam int P_SF = 4;
  localparam int P_DB = 11;
  localparam logic [31:0] CFG_RST [NREG] = '{
    32'h0000_0010, 32'h0000_0099, 32'h0000_3c00,
    32'h0028_0409, 32'h0001_e113};
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_ON = 2'h1;
  localparam logic [1:0] CMD_OFF = 2'h2;
  localparam logic [1:0] BRR_NONE = 2'h0;
  localparam logic [1:0] BRR_ON = 2'h1;
  localparam logic [1:0] BRR_OFF = 2'h2;
  localparam logic [1:0] BRR_CUR = 2'h3;
  localparam logic [1:0] CYC_ON = 2'h1;
  localparam logic [1:0] CYC_OFF = 2'h2;
  localparam logic [1:0] CYC_ALL = 2'h3;
  localparam logic [2:0] OP_SINGLE = 3'h0;
  localparam logic [2:0] OP_BRT_ON = 3'h1;
  localparam logic [2:0] OP_DRK_OFF = 3'h2;
  localparam logic [2:0] OP_BRT_TGL = 3'h3;
  localparam logic [3:0] CYC_BOFS = 4'h3;
  localparam logic [3:0] CYC2_NONE = 4'hc;
  localparam int T_START = 0;
  localparam int T_LONG = 1;
  localparam int T_REP = 2;
  localparam int T_CYC1 = 3;
  localparam int T_CYC2 = 4;
  localparam int NT = 5;
  // time bases in ms, 130 ms up to 1.2 h
  localparam logic [22:0] TB_MS [16] = '{
    23'd130, 23'd260, 23'd520, 23'd1000, 23'd2100, 23'd4200,
    23'd8400, 23'd17000, 23'd34000, 23'd66000, 23'd132000,
    23'd270000, 23'd540000, 23'd1080000, 23'd2100000, 23'd4320000};
  typedef enum logic [1:0] {
    PBD_IDLE = 2'b00,
    PBD_WAIT = 2'b01,
    PBD_LONG = 2'b11
  } pbd_press_t;
endpackage

/* src/pbd_top.sv */
// Operation
// - rising edge applies object 2 rise command
// - falling edge applies object 2 fall command
// - cyclic resend off, on ON, OFF, always
// - cyclic period is object base, shifted up by CYC_BOFS steps, times factor
// - object 2 base may disable its cycling
// - switching bus-return reaction after startup delay
// - dimming bus-return reaction after startup delay
// - single area: short toggles, long alternates direction
// - brighter-on: short ON, long brighter
// - darker-off: short OFF, long darker
// - toggle variants: short toggles, long fixed direction
// - brighter telegram carries brighter step width
// - darker telegram carries own step width
// - long press after base times factor
// - optional stop telegram on release
// - optional dimming repeat while held
// - repeat interval is base times factor
// - startup delay silences inputs and telegrams
// - edges taken after debounce time
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module pbd_top #(
  parameter int TICK_CYCLES = pbd_pkg::TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic btn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tg_valid,
  output logic [1:0] tg_kind,
  output logic [3:0] tg_data,
  input wire logic tg_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  logic [31:0] cfg_q [pbd_pkg::NREG];
  logic [15:0] tk_q;
  logic init_q, rdy_q, stb_q, dir_q;
  logic [7:0] db_cnt_q;
  logic [1:0] obj_q, obj_d;
  logic [3:0] snd_q, snd_set;
  logic dir_d;
  logic [1:0] r;
  pbd_pkg::pbd_press_t pst_q, pst_d;
  logic [pbd_pkg::NT-1:0] t_ld;
  logic [30:0] t_val [pbd_pkg::NT];
  logic [30:0] t_cnt_q [pbd_pkg::NT];
  logic got_aw_q, got_w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;

  function automatic logic [30:0] ticks(input logic [3:0] b,
                                        input logic [6:0] f);
    return 31'({pbd_pkg::TB_MS[b], 1'b0}) * 31'(f);
  endfunction

  function automatic logic [1:0] sw_cmd(input logic [1:0] c,
                                        input logic v);
    if (c == pbd_pkg::CMD_NONE)
      return {1'b0, v};
    else if (c == pbd_pkg::CMD_ON)
      return 2'b11;
    else if (c == pbd_pkg::CMD_OFF)
      return 2'b10;
    else
      return {1'b1, ~v};
  endfunction

  // configuration fields
  wire mode_dim = cfg_q[0][pbd_pkg::C_MODE];
  wire [2:0] op = cfg_q[0][pbd_pkg::C_OP +: 3];
  wire stop_en = cfg_q[0][pbd_pkg::C_STOP];
  wire rep_en = cfg_q[0][pbd_pkg::C_REP];
  wire [1:0] brr = cfg_q[0][pbd_pkg::C_BRR +: 2];
  wire [1:0] cyc = cfg_q[0][pbd_pkg::C_CYC +: 2];
  wire [1:0] rc [2] = '{cfg_q[1][pbd_pkg::S_R1 +: 2],
                        cfg_q[1][pbd_pkg::S_R2 +: 2]};
  wire [1:0] fc [2] = '{cfg_q[1][pbd_pkg::S_F1 +: 2],
                        cfg_q[1][pbd_pkg::S_F2 +: 2]};
  wire [3:0] cb1 = cfg_q[2][pbd_pkg::Y_B1 +: 4];
  wire [3:0] cb2 = cfg_q[2][pbd_pkg::Y_B2 +: 4];
  wire [6:0] cfac = cfg_q[2][pbd_pkg::Y_FAC +: 7];
  wire [2:0] st_up = cfg_q[3][pbd_pkg::D_UP +: 3];
  wire [2:0] st_dn = cfg_q[3][pbd_pkg::D_DN +: 3];
  wire [3:0] lb = {2'b00, cfg_q[3][pbd_pkg::D_LB +: 2]};
  wire [6:0] lf = cfg_q[3][pbd_pkg::D_LF +: 7];
  wire [3:0] rb = {2'b00, cfg_q[3][pbd_pkg::D_RB +: 2]};
  wire [6:0] rf = cfg_q[3][pbd_pkg::D_RF +: 7];
  wire [3:0] sb = cfg_q[4][pbd_pkg::P_SB +: 4];
  wire [6:0] sf = cfg_q[4][pbd_pkg::P_SF +: 7];
  wire [7:0] dbf = cfg_q[4][pbd_pkg::P_DB +: 8];
  wire cyc2_off = cb2 == pbd_pkg::CYC2_NONE;

  // shared 0.5 ms tick
  wire tick = tk_q == 16'(TICK_CYCLES - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tk_q <= 16'h0;
    else if (ce)
      tk_q <= tick ? 16'h0 : tk_q + 16'h1;
  end

  // debounce and edge detection
  wire db_hit = btn != stb_q && db_cnt_q >= dbf;
  wire ev_rise = db_hit && btn && rdy_q;
  wire ev_fall = db_hit && !btn && rdy_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stb_q <= 1'b0;
      db_cnt_q <= 8'h0;
    end
    else if (ce)
    begin
      if (btn == stb_q || db_hit)
        db_cnt_q <= 8'h0;
      else if (tick)
        db_cnt_q <= db_cnt_q + 8'h1;
      if (db_hit)
        stb_q <= btn;
    end
  end
  stb_wait_a: assert property ($changed(stb_q) |->
    $past(db_cnt_q) >= $past(dbf))
    else $error("input edge taken before debounce time");

  // down counters, loaded from base times factor
  wire ready_w = init_q && t_cnt_q[pbd_pkg::T_START] == 31'd0;
  wire react = ready_w && !rdy_q;
  wire [pbd_pkg::NT-1:0] t_exp;
  for (genvar i = 0; i < pbd_pkg::NT; i++)
  begin : g_tmr
    assign t_exp[i] = tick && t_cnt_q[i] == 31'd1;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        t_cnt_q[i] <= 31'd0;
      else if (ce)
      begin
        if (t_ld[i])
          t_cnt_q[i] <= t_val[i];
        else if (tick && t_cnt_q[i] != 31'd0)
          t_cnt_q[i] <= t_cnt_q[i] - 31'd1;
      end
    end
  end
  wire cyc_go = react || rdy_q;
  assign t_ld = {
    cyc_go && (react || t_exp[pbd_pkg::T_CYC2]),
    cyc_go && (react || t_exp[pbd_pkg::T_CYC1]),
    (pst_q == pbd_pkg::PBD_WAIT && t_exp[pbd_pkg::T_LONG]) ||
      t_exp[pbd_pkg::T_REP] || ev_fall,
    mode_dim && (ev_rise || ev_fall),
    !init_q};
  assign t_val[pbd_pkg::T_START] = ticks(sb, sf);
  assign t_val[pbd_pkg::T_LONG] = ev_rise ? ticks(lb, lf) : 31'd0;
  assign t_val[pbd_pkg::T_REP] = (ev_fall || !rep_en) ? 31'd0 :
    ticks(rb, rf);
  assign t_val[pbd_pkg::T_CYC1] = mode_dim ? 31'd0 :
    ticks(cb1 + pbd_pkg::CYC_BOFS, cfac);
  assign t_val[pbd_pkg::T_CYC2] = (mode_dim || cyc2_off) ? 31'd0 :
    ticks(cb2 + pbd_pkg::CYC_BOFS, cfac);
  cyc2_off_a: assert property (t_ld[pbd_pkg::T_CYC2] && cyc2_off |=>
    t_cnt_q[pbd_pkg::T_CYC2] == 31'd0)
    else $error("object 2 cycling not disabled");

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      init_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else if (ce)
    begin
      init_q <= 1'b1;
      rdy_q <= ready_w;
    end
  end

  // cyclic condition per object
  wire [1:0] cyc_ok;
  for (genvar k = 0; k < 2; k++)
  begin : g_cyc
    assign cyc_ok[k] = cyc == pbd_pkg::CYC_ALL ||
      (cyc == pbd_pkg::CYC_ON && obj_q[k]) ||
      (cyc == pbd_pkg::CYC_OFF && !obj_q[k]);
  end
  wire dim_up = op == pbd_pkg::OP_SINGLE ? dir_q :
    (op == pbd_pkg::OP_BRT_ON || op == pbd_pkg::OP_BRT_TGL);
  wire fix_on = op == pbd_pkg::OP_BRT_ON;
  wire fix_off = op == pbd_pkg::OP_DRK_OFF;

  always_comb
  begin
    obj_d = obj_q;
    dir_d = dir_q;
    pst_d = pst_q;
    snd_set = 4'h0;
    r = 2'b00;
    if (react && !mode_dim)
    begin
      unique case (brr)
        pbd_pkg::BRR_NONE: ;
        pbd_pkg::BRR_ON:
        begin
          obj_d = 2'b11;
          snd_set[1:0] = 2'b11;
        end
        pbd_pkg::BRR_OFF:
        begin
          obj_d = 2'b00;
          snd_set[1:0] = 2'b11;
        end
        pbd_pkg::BRR_CUR:
          for (int k = 0; k < 2; k++)
          begin
            r = stb_q ? sw_cmd(rc[k], obj_q[k]) : sw_cmd(fc[k], obj_q[k]);
            obj_d[k] = r[0];
            snd_set[k] = r[1];
          end
      endcase
    end
    else if (react)
    begin
      if (brr == pbd_pkg::BRR_ON || brr == pbd_pkg::BRR_OFF)
      begin
        obj_d[0] = brr == pbd_pkg::BRR_ON;
        snd_set[0] = 1'b1;
      end
    end
    else if (!mode_dim)
    begin
      for (int k = 0; k < 2; k++)
      begin
        r = ev_rise ? sw_cmd(rc[k], obj_q[k]) : sw_cmd(fc[k], obj_q[k]);
        if (ev_rise || ev_fall)
        begin
          obj_d[k] = r[0];
          snd_set[k] = r[1];
        end
      end
      if (t_exp[pbd_pkg::T_CYC1] && cyc_ok[0])
        snd_set[0] = 1'b1;
      if (t_exp[pbd_pkg::T_CYC2] && cyc_ok[1])
        snd_set[1] = 1'b1;
    end
    else
    begin
      unique case (pst_q)
        pbd_pkg::PBD_IDLE:
          if (ev_rise)
            pst_d = pbd_pkg::PBD_WAIT;
        pbd_pkg::PBD_WAIT:
          if (ev_fall)
          begin
            pst_d = pbd_pkg::PBD_IDLE;
            obj_d[0] = fix_on ||
              (!fix_off && !obj_q[0]);
            snd_set[0] = 1'b1;
          end
          else if (t_exp[pbd_pkg::T_LONG])
          begin
            pst_d = pbd_pkg::PBD_LONG;
            if (op == pbd_pkg::OP_SINGLE)
              dir_d = !dir_q;
            snd_set[2] = 1'b1;
          end
        pbd_pkg::PBD_LONG:
          if (ev_fall)
          begin
            pst_d = pbd_pkg::PBD_IDLE;
            snd_set[3] = stop_en;
          end
          else if (t_exp[pbd_pkg::T_REP] && rep_en)
            snd_set[2] = 1'b1;
        default:
          pst_d = pbd_pkg::PBD_IDLE;
      endcase
    end
  end

  // telegram request, one deep, held until acknowledged
  wire [3:0] pick = snd_q & (~snd_q + 4'h1);
  wire [3:0] snd_clr = tg_valid ? 4'h0 : pick;
  wire [1:0] pk = {pick[3] | pick[2], pick[3] | pick[1]};
  wire [2:0] step = dim_up ? st_up : st_dn;
  wire [3:0] pd = pick[0] ? {3'b000, obj_q[0]} :
    pick[1] ? {3'b000, obj_q[1]} : {dim_up, pick[2] ? step : 3'b000};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      obj_q <= 2'b00;
      dir_q <= 1'b0;
      pst_q <= pbd_pkg::PBD_IDLE;
      snd_q <= 4'h0;
    end
    else if (ce)
    begin
      obj_q <= obj_d;
      dir_q <= dir_d;
      pst_q <= pst_d;
      snd_q <= (snd_q & ~snd_clr) | snd_set;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tg_valid <= 1'b0;
      tg_kind <= 2'b00;
      tg_data <= 4'h0;
    end
    else if (ce)
    begin
      if (tg_valid)
        tg_valid <= !tg_ack;
      else if (|snd_q)
      begin
        tg_valid <= 1'b1;
        tg_kind <= pk;
        tg_data <= pd;
      end
    end
  end

  sequence s_long_start;
    pst_q == pbd_pkg::PBD_WAIT && !ev_fall && t_exp[pbd_pkg::T_LONG];
  endsequence
  sequence s_release;
    pst_q == pbd_pkg::PBD_LONG && ev_fall;
  endsequence
  rise_cmd_a: assert property (!mode_dim && !react && ev_rise &&
    rc[1] == pbd_pkg::CMD_ON |=> obj_q[1] && snd_q[1])
    else $error("rise command on object 2 not applied");
  fall_cmd_a: assert property (!mode_dim && !react && ev_fall &&
    fc[1] == pbd_pkg::CMD_OFF |=> !obj_q[1] && snd_q[1])
    else $error("fall command on object 2 not applied");
  long_dim_a: assert property (s_long_start |=> pst_q ==
    pbd_pkg::PBD_LONG && snd_q[2])
    else $error("long press did not start dimming");
  dir_alt_a: assert property (s_long_start ##0 op == pbd_pkg::OP_SINGLE
    |=> dir_q != $past(dir_q))
    else $error("dimming direction did not alternate");
  short_on_a: assert property (mode_dim && pst_q == pbd_pkg::PBD_WAIT &&
    ev_fall && fix_on |=> obj_q[0] && snd_q[0])
    else $error("short press did not send on");
  stop_tg_a: assert property (s_release ##0 stop_en |=> snd_q[3] ##[0:8]
    tg_valid && tg_kind == 2'h3)
    else $error("stop telegram missing on release");
  start_quiet_a: assert property (!rdy_q |-> !tg_valid &&
    snd_q == 4'h0)
    else $error("telegram during startup delay");
  req_hold_a: assert property (tg_valid && !tg_ack |=> tg_valid &&
    $stable(tg_kind) && $stable(tg_data))
    else $error("telegram request dropped before acknowledge");

  // register slave
  wire [2:0] wi = awa_q[4:2];
  wire [2:0] ri = s_axi_araddr[4:2];
  wire wr_ok = awa_q[7:5] == 3'h0 && wi < pbd_pkg::STAT_IDX;
  wire rd_ok = s_axi_araddr[7:5] == 3'h0 && ri <= pbd_pkg::STAT_IDX;
  wire do_wr = got_aw_q && got_w_q && !s_axi_bvalid;
  wire [31:0] stat_w = {24'h0, pst_q, tg_valid, rdy_q, stb_q, dir_q,
    obj_q};
  wire [31:0] rd_w = !rd_ok ? 32'h0 :
    ri == pbd_pkg::STAT_IDX ? stat_w : cfg_q[ri];
  wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}},
    {8{ws_q[0]}}};
  for (genvar i = 0; i < pbd_pkg::NREG; i++)
  begin : g_cfg
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        cfg_q[i] <= pbd_pkg::CFG_RST[i];
      else if (ce && do_wr && wr_ok && wi == 3'(i))
        cfg_q[i] <= (cfg_q[i] & ~wmask) | (wd_q & wmask);
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      got_aw_q <= 1'b0;
      got_w_q <= 1'b0;
      awa_q <= 8'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        got_aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        got_w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        got_aw_q <= 1'b0;
        got_w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_w;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

/* tb/pbd_tx_model.sv */
`timescale 1ns/1ns
module pbd_tx_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic tg_valid,
  input wire logic [1:0] tg_kind,
  input wire logic [3:0] tg_data,
  output logic tg_ack,
  output logic rx_stb,
  output logic [5:0] rx_word,
  output logic held_err
);
  logic [3:0] wait_q;
  logic [5:0] seen_q;
  // acks at once or after five cycles; flags a payload that moves
  always_ff @(posedge aclk)
  begin
    rx_stb <= 1'b0;
    if (!aresetn)
    begin
      tg_ack <= 1'b0;
      wait_q <= 4'h0;
      held_err <= 1'b0;
    end
    else if (tg_valid && tg_ack)
    begin
      tg_ack <= 1'b0; // one telegram per request
      rx_stb <= 1'b1;
      rx_word <= {tg_kind, tg_data};
      wait_q <= 4'h0;
    end
    else if (tg_valid)
    begin
      if (wait_q != 4'h0 && seen_q != {tg_kind, tg_data})
        held_err <= 1'b1; // request must stand until acked
      seen_q <= {tg_kind, tg_data};
      wait_q <= wait_q + 4'h1;
      tg_ack <= !slow || wait_q == 4'h5;
    end
  end
endmodule

/* tb/tb_pbd_top.sv */
`timescale 1ns/1ns
module tb_pbd_top;
  logic aclk, aresetn, btn, slow, tg_valid, tg_ack, rx_stb, held_err;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, o1, v2, sdir;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, tg_kind;
  logic [3:0] tg_data;
  logic [5:0] rx_word;
  logic [5:0] rxq[$];
  int rxt[$];
  int cyc = 0;
  int num_errors = 0;
  int checks_done = 0;
  pbd_top #(.TICK_CYCLES(1)) DUT (.ce(1'b1), .s_axi_wstrb(4'hf), .*);
  pbd_tx_model TX (.*);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (rx_stb)
    begin
      rxq.push_back(rx_word);
      rxt.push_back(cyc);
    end
  end
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e)
      fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    for (n = 0; n < 50 && !b; n++)
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      if (b)
        s_axi_bready <= 1'b0;
    end
    if (!b)
      fail("write timeout");
    else
      chk(r, er, "write response");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar, got;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 50 && !got; n++)
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar)
        s_axi_arvalid <= 1'b0;
      if (got)
        s_axi_rready <= 1'b0;
    end
    if (!got)
      fail("read timeout");
  endtask
  task automatic hold(input logic v, input int n);
    @(posedge aclk);
    btn <= v;
    repeat (n) @(posedge aclk);
  endtask
  task automatic pop(input logic [5:0] e);
    if (rxq.size() == 0)
      fail("telegram missing");
    else
    begin
      chk(rxq.pop_front(), e, "telegram");
      void'(rxt.pop_front());
    end
  endtask
  task automatic none();
    chk(rxq.size(), 0, "unexpected telegram count");
    rxq.delete();
    rxt.delete();
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < pbd_pkg::NREG; i++)
    begin
      rd(8'(i * 4), d, r);
      chk(d, pbd_pkg::CFG_RST[i], "reset value");
    end
    rd(8'h18, d, r);
    chk(r, 2'h2, "unmapped read");
    wr(8'h14, 32'h0, 2'h2);
    wr(8'h20, 32'hffff_ffff, 2'h2);
    rd(8'h00, d, r);
    chk(d, pbd_pkg::CFG_RST[0], "refused write stored");
    $display("t_regs done");
  endtask
  task automatic t_startup();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h00, 32'h0000_01d0, 2'h0);
    wr(8'h08, 32'h0000_03c0, 2'h0);
    wr(8'h04, 32'h0000_0090, 2'h0);
    hold(1'b1, 300);
    hold(1'b0, 300);
    d = 32'h0;
    for (int n = 0; n < 20000 && d[4] !== 1'b1; n++)
      rd(8'h14, d, r);
    chk(d[4], 1'b1, "startup done");
    repeat (50) @(posedge aclk);
    pop(6'h10);
    none();
    $display("t_startup done");
  endtask
  task automatic t_switch();
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      slow <= c[0];
      wr(8'h04, {24'h0, c, c, 4'h0}, 2'h0);
      for (int e = 0; e < 2; e++)
      begin
        hold(e == 0, 200);
        if (c == 2'h0)
          none();
        else
        begin
          v2 = (c == 2'h3) ? !v2 : (c == 2'h1);
          pop({2'd1, 3'h0, v2});
        end
      end
    end
    wr(8'h04, 32'h0000_0010, 2'h0);
    hold(1'b1, 20);
    hold(1'b0, 200);
    none();
    hold(1'b1, 200);
    pop(6'h11);
    hold(1'b0, 200);
    none();
    $display("t_switch done");
  endtask
  task automatic t_cyclic();
    int d;
    wr(8'h04, 32'h0000_0001, 2'h0);
    hold(1'b1, 200);
    pop(6'h01);
    o1 = 1'b1;
    hold(1'b0, 200);
    none();
    for (int n = 0; n < 15000 && rxq.size() < 2; n++)
      @(posedge aclk);
    chk(rxq.size(), 2, "cyclic count");
    if (rxq.size() == 2)
    begin
      d = rxt[1] - rxt[0];
      chk(d >= 5998 && d <= 6002, 1'b1, "cyclic period");
    end
    pop(6'h01);
    pop(6'h01);
    wr(8'h00, 32'h0000_02d0, 2'h0);
    repeat (7000) @(posedge aclk);
    none();
    $display("t_cyclic done");
  endtask
  task automatic t_dim(input logic [2:0] op, input logic stp,
                       input logic rep);
    logic dir;
    int d;
    wr(8'h00, {22'h0, 4'h0, rep, stp, op, 1'b1}, 2'h0);
    hold(1'b1, 300);
    hold(1'b0, 200);
    o1 = (op == 3'h1) ? 1'b1 : (op == 3'h2) ? 1'b0 : !o1;
    pop({2'd0, 3'h0, o1});
    if (op == 3'h0)
      sdir = !sdir;
    dir = (op == 3'h0) ? sdir : (op == 3'h1 || op == 3'h3);
    hold(1'b1, rep ? 2900 : 1300);
    hold(1'b0, 200);
    if (rep && rxq.size() > 1)
    begin
      d = rxt[1] - rxt[0];
      chk(d >= 778 && d <= 782, 1'b1, "repeat interval");
    end
    for (int k = 0; k < (rep ? 3 : 1); k++)
      pop({2'd2, dir, dir ? 3'd2 : 3'd5});
    if (stp)
      pop({2'd3, dir, 3'd0});
    none();
    $display("t_dim op %0d done", op);
  endtask
  task automatic t_dim_return();
    int t0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t0 = cyc;
    wr(8'h00, 32'h0000_0041, 2'h0);
    repeat (34100) @(posedge aclk);
    if (rxt.size() > 0)
      chk(rxt[0] - t0 >= 34000 && rxt[0] - t0 <= 34030, 1'b1,
          "startup length");
    pop(6'h01);
    none();
    $display("t_dim_return done");
  endtask
  initial
  begin
    aresetn = 1'b0;
    btn = 1'b0;
    slow = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    o1 = 1'b0;
    v2 = 1'b0;
    sdir = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_startup();
    t_switch();
    t_cyclic();
    wr(8'h0c, 32'h000c_042a, 2'h0);
    t_dim(3'h0, 1'b1, 1'b0);
    t_dim(3'h0, 1'b0, 1'b0);
    t_dim(3'h1, 1'b1, 1'b1);
    t_dim(3'h2, 1'b0, 1'b0);
    t_dim(3'h3, 1'b1, 1'b0);
    t_dim(3'h4, 1'b0, 1'b1);
    t_dim_return();
    chk(held_err, 1'b0, "request moved before ack");
    close_out();
  end
  initial
  begin
    repeat (120000) @(posedge aclk);
    fail("run timeout");
    close_out();
  end
endmodule
